// *** rtc_ctl_pkg.sv ***
package rtc_ctl_pkg;

    // ============================================================
    // Register map: the host address space is 7 bits wide.
    localparam int             ADDR_W              = 7;
    localparam logic [6:0]     OFS_SEC             = 7'h00;
    localparam logic [6:0]     OFS_SEC_ALARM       = 7'h01;
    localparam logic [6:0]     OFS_MIN             = 7'h02;
    localparam logic [6:0]     OFS_MIN_ALARM       = 7'h03;
    localparam logic [6:0]     OFS_HOUR            = 7'h04;
    localparam logic [6:0]     OFS_HOUR_ALARM      = 7'h05;
    localparam logic [6:0]     OFS_RATE_CTRL       = 7'h0a;
    localparam logic [6:0]     OFS_CLOCK_CONTROL   = 7'h0b;
    localparam logic [6:0]     OFS_INTERRUPT_FLAGS = 7'h0c;
    localparam logic [6:0]     OFS_BACKUP_STATUS   = 7'h0d;
    localparam logic [6:0]     OFS_RAM_FIRST       = 7'h0e;
    localparam logic [6:0]     OFS_EXT_FIRST       = 7'h40;
    localparam logic [6:0]     OFS_EXT_FLAGS       = 7'h4a;
    localparam logic [6:0]     OFS_EXT_ENABLES     = 7'h4b;
    localparam int             RAM_DEPTH           = 114;

    // ============================================================
    // Field positions in the clock control register.
    localparam int             CC_FREEZE           = 7;
    localparam int             CC_PER_EN           = 6;
    localparam int             CC_ALM_EN           = 5;
    localparam int             CC_UPD_EN           = 4;
    localparam int             CC_SQW_EN           = 3;
    localparam int             CC_DATA_FMT         = 2;
    localparam int             CC_HOUR24           = 1;
    localparam int             CC_DST_EN           = 0;

    // Field positions in the rate control and extended registers.
    localparam int             RC_PENDING          = 7;
    localparam int             RC_BANK             = 4;
    localparam int             EXT_WAKEUP          = 0;
    localparam int             EXT_KICKSTART       = 1;
    localparam int             EXT_RAM_CLEAR       = 2;
    localparam int             EXT_FORCE_32K       = 5;

    // ============================================================
    // Reset values and match constants.
    localparam logic [7:0]     RST_CLOCK_CONTROL   = 8'h08;
    localparam logic [6:0]     RST_RATE_CTRL       = 7'h20;
    localparam logic [1:0]     ALARM_ANY           = 2'h3;
    localparam logic [7:0]     LAST_SEC_BCD        = 8'h59;
    localparam logic [7:0]     LAST_SEC_BIN        = 8'h3b;
    localparam logic [7:0]     HOUR_ONE            = 8'h01;
    localparam logic [3:0]     RATE_NONE           = 4'h0;

endpackage

// *** rtc_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Freeze blocks user time updates; else advance
// - Freeze rising clears update-ended enable
// - Periodic flag always sets; enable gates interrupt
// - Alarm on time match; 11xxxxxx matches all
// - Square wave follows enable; forced on at power-up
// - Data format bit selects binary or BCD
// - Hour format bit selects 24 or 12 hours
// - April first Sunday skips 2 AM hour
// - October last Sunday falls back once only
// - Sunday test at midnight; none when disabled
// - Summary flag ORs six flag enable pairs
// - Periodic flag sets on selected tap edge
// - Alarm flag on match; update flag per update
// - Flag read latched, cleared, new events kept
// - Flag register low nibble reads zero
// - Valid bit from backup supplies; rest zero
// - Extended flags clear only by writing zero
// - Enabling a set flag asserts interrupt immediately
// - Interrupt held while any enabled flag set
// - User RAM always accessible; 114 bytes bank 0
// - Bank select bit maps bank 0 or 1
// - Force 32 kHz overrides rate select
module rtc_ctl (
    // Clock and reset.
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,

    // Host register port.
    input  wire logic [6:0]  addr_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    output logic      [7:0]  rd_data_o,

    // Divider chain and timekeeping counters.
    input  wire logic [15:1] rate_tap_i,
    input  wire logic        tap_32khz_i,
    input  wire logic        update_pending_i,
    input  wire logic        update_done_i,
    input  wire logic [7:0]  count_sec_i,
    input  wire logic [7:0]  count_min_i,
    input  wire logic [7:0]  count_hour_i,
    input  wire logic        midnight_i,
    input  wire logic        first_sunday_april_i,
    input  wire logic        last_sunday_october_i,

    // Extended event sources.
    input  wire logic        wakeup_event_i,
    input  wire logic        kickstart_event_i,
    input  wire logic        ram_clear_event_i,

    // Backup supply comparators (asynchronous pins).
    input  wire logic        vbat_ok_i,
    input  wire logic        vbaux_ok_i,

    // Controls to the timekeeping counters.
    output logic             freeze_o,
    output logic             data_format_select_o,
    output logic             hour_24_o,
    output logic      [2:0]  divider_ctrl_o,
    output logic             dst_skip_hour_o,
    output logic             dst_fall_back_o,

    // Pins.
    output logic             square_wave_out_o,
    output logic             irq_n_o
);

    // ============================================================
    // State.
    typedef struct packed {
        logic [7:0] ctrl;
        logic [6:0] rate_ctrl;
        logic       periodic_flag;
        logic       alarm_flag;
        logic       update_done_flag;
        logic [2:0] ext_flags;
        logic [2:0] ext_en;
        logic       force_32khz_out;
        logic [7:0] user_sec;
        logic [7:0] user_min;
        logic [7:0] user_hour;
        logic [7:0] alarm_sec;
        logic [7:0] alarm_min;
        logic [7:0] alarm_hour;
        logic       tap_prev;
        logic       spring_armed;
        logic       fall_armed;
        logic [1:0] supply_s1;
        logic [1:0] supply_s2;
        logic [7:0] rd_data;
        logic       irq_n;
        logic       square_wave_out;
        logic       dst_skip;
        logic       dst_back;
    } state_t;

    localparam int RAM_DEPTH = rtc_ctl_pkg::RAM_DEPTH;

    state_t     cur;
    state_t     next_state;
    // User RAM is not reset, so its bytes survive a reset.
    logic [7:0] user_ram [RAM_DEPTH];

    // ============================================================
    // Helpers.

    // An alarm byte matches its time byte or holds the any-value code.
    function automatic logic alarm_match(input logic [7:0] alarm, input logic [7:0] value);
        alarm_match = (alarm[7:6] == rtc_ctl_pkg::ALARM_ANY) || (alarm == value);
    endfunction

    // Summary of the six flag and enable pairs.
    function automatic logic any_irq(input state_t s);
        any_irq = (s.periodic_flag & s.ctrl[rtc_ctl_pkg::CC_PER_EN])
                | (s.alarm_flag & s.ctrl[rtc_ctl_pkg::CC_ALM_EN])
                | (s.update_done_flag & s.ctrl[rtc_ctl_pkg::CC_UPD_EN])
                | (|(s.ext_flags & s.ext_en));
    endfunction

    // Last second of a minute, in the selected data format.
    function automatic logic is_last_sec(input logic [7:0] value, input logic binary);
        is_last_sec = binary ? (value == rtc_ctl_pkg::LAST_SEC_BIN)
                             : (value == rtc_ctl_pkg::LAST_SEC_BCD);
    endfunction

    // ============================================================
    // Address decode for the host port.
    logic       in_ram;
    logic       in_ext;
    logic [6:0] ram_index;
    logic       bank1;

    always_comb begin
        bank1     = cur.rate_ctrl[rtc_ctl_pkg::RC_BANK];
        // In bank 1 the upper 64 bytes become extended registers.
        // bank select decode
        in_ext    = bank1 && (addr_i >= rtc_ctl_pkg::OFS_EXT_FIRST);
        in_ram    = (addr_i >= rtc_ctl_pkg::OFS_RAM_FIRST) && !in_ext;
        ram_index = addr_i - rtc_ctl_pkg::OFS_RAM_FIRST;
    end

    // ============================================================
    // Next-state logic.
    logic       wr_ctrl;
    logic       rd_flags;
    logic       alarm_hit;
    logic       periodic_edge;
    logic       tap_now;
    logic       one_59_59;
    logic [7:0] read_value;

    always_comb begin
        next_state = cur;

        wr_ctrl  = wr_en_i && (addr_i == rtc_ctl_pkg::OFS_CLOCK_CONTROL);
        rd_flags = rd_en_i && (addr_i == rtc_ctl_pkg::OFS_INTERRUPT_FLAGS);

        // Backup supply pins pass two flip-flops before use.
        next_state.supply_s1 = {vbaux_ok_i, vbat_ok_i};
        next_state.supply_s2 = cur.supply_s1;

        // Clock control register; formats are never touched internally.
        // data format stored
        if (wr_ctrl) begin
            next_state.ctrl = wr_data_i;
            if (wr_data_i[rtc_ctl_pkg::CC_FREEZE] && !cur.ctrl[rtc_ctl_pkg::CC_FREEZE]) begin
                next_state.ctrl[rtc_ctl_pkg::CC_UPD_EN] = 1'b0;
            end
        end

        // Rate control, time, alarm and extended enable registers.
        if (wr_en_i) begin
            if (addr_i == rtc_ctl_pkg::OFS_RATE_CTRL) begin
                next_state.rate_ctrl = wr_data_i[6:0];
            end else if (addr_i == rtc_ctl_pkg::OFS_SEC) begin
                next_state.user_sec = wr_data_i;
            end else if (addr_i == rtc_ctl_pkg::OFS_MIN) begin
                next_state.user_min = wr_data_i;
            end else if (addr_i == rtc_ctl_pkg::OFS_HOUR) begin
                next_state.user_hour = wr_data_i;
            end else if (addr_i == rtc_ctl_pkg::OFS_SEC_ALARM) begin
                next_state.alarm_sec = wr_data_i;
            end else if (addr_i == rtc_ctl_pkg::OFS_MIN_ALARM) begin
                next_state.alarm_min = wr_data_i;
            end else if (addr_i == rtc_ctl_pkg::OFS_HOUR_ALARM) begin
                next_state.alarm_hour = wr_data_i;
            end else if (in_ext && (addr_i == rtc_ctl_pkg::OFS_EXT_ENABLES)) begin
                next_state.ext_en          = wr_data_i[2:0];
                next_state.force_32khz_out = wr_data_i[rtc_ctl_pkg::EXT_FORCE_32K];
            end
        end

        if (update_done_i && !cur.ctrl[rtc_ctl_pkg::CC_FREEZE]) begin
            next_state.user_sec  = count_sec_i;
            next_state.user_min  = count_min_i;
            next_state.user_hour = count_hour_i;
        end

        tap_now            = (cur.rate_ctrl[3:0] != rtc_ctl_pkg::RATE_NONE)
                             && rate_tap_i[cur.rate_ctrl[3:0]];
        next_state.tap_prev = tap_now;
        periodic_edge      = tap_now && !cur.tap_prev;

        alarm_hit = update_done_i
                    && alarm_match(cur.alarm_sec, count_sec_i)
                    && alarm_match(cur.alarm_min, count_min_i)
                    && alarm_match(cur.alarm_hour, count_hour_i);

        // Flags: a flag read clears them at the end of the strobe, and an
        // event in that same cycle is posted after the clear.
        // clear on read, set wins
        if (rd_flags) begin
            next_state.periodic_flag    = 1'b0;
            next_state.alarm_flag       = 1'b0;
            next_state.update_done_flag = 1'b0;
        end

        if (periodic_edge) begin
            next_state.periodic_flag = 1'b1;
        end

        if (alarm_hit) begin
            next_state.alarm_flag = 1'b1;
        end
        if (update_done_i) begin
            next_state.update_done_flag = 1'b1;
        end

        if (wr_en_i && in_ext && (addr_i == rtc_ctl_pkg::OFS_EXT_FLAGS)) begin
            next_state.ext_flags = cur.ext_flags & wr_data_i[2:0];
        end

        // Events set their extended flag after any clear by write.
        next_state.ext_flags[rtc_ctl_pkg::EXT_WAKEUP] =
            next_state.ext_flags[rtc_ctl_pkg::EXT_WAKEUP] | wakeup_event_i;
        next_state.ext_flags[rtc_ctl_pkg::EXT_KICKSTART] =
            next_state.ext_flags[rtc_ctl_pkg::EXT_KICKSTART] | kickstart_event_i;
        next_state.ext_flags[rtc_ctl_pkg::EXT_RAM_CLEAR] =
            next_state.ext_flags[rtc_ctl_pkg::EXT_RAM_CLEAR] | ram_clear_event_i;

        if (midnight_i) begin
            next_state.spring_armed = cur.ctrl[rtc_ctl_pkg::CC_DST_EN] && first_sunday_april_i;
            next_state.fall_armed   = cur.ctrl[rtc_ctl_pkg::CC_DST_EN] && last_sunday_october_i;
        end

        // Adjustments fire when the counters show 1:59:59 in the morning.
        one_59_59 = update_done_i
                    && (count_hour_i == rtc_ctl_pkg::HOUR_ONE)
                    && is_last_sec(count_min_i, cur.ctrl[rtc_ctl_pkg::CC_DATA_FMT])
                    && is_last_sec(count_sec_i, cur.ctrl[rtc_ctl_pkg::CC_DATA_FMT]);

        next_state.dst_skip = 1'b0;
        next_state.dst_back = 1'b0;
        if (one_59_59 && cur.ctrl[rtc_ctl_pkg::CC_DST_EN]) begin
            if (cur.spring_armed) begin
                next_state.dst_skip     = 1'b1;
                next_state.spring_armed = 1'b0;
            end

            if (cur.fall_armed) begin
                next_state.dst_back   = 1'b1;
                next_state.fall_armed = 1'b0;
            end
        end

        next_state.irq_n = !any_irq(next_state);

        if (cur.force_32khz_out) begin
            next_state.square_wave_out = tap_32khz_i;
        end else begin
            next_state.square_wave_out = cur.ctrl[rtc_ctl_pkg::CC_SQW_EN] && tap_now;
        end

        // Read data, valid only in the cycle after the strobe.
        read_value = 8'h00;
        if (addr_i == rtc_ctl_pkg::OFS_SEC) begin
            read_value = cur.user_sec;
        end else if (addr_i == rtc_ctl_pkg::OFS_SEC_ALARM) begin
            read_value = cur.alarm_sec;
        end else if (addr_i == rtc_ctl_pkg::OFS_MIN) begin
            read_value = cur.user_min;
        end else if (addr_i == rtc_ctl_pkg::OFS_MIN_ALARM) begin
            read_value = cur.alarm_min;
        end else if (addr_i == rtc_ctl_pkg::OFS_HOUR) begin
            read_value = cur.user_hour;
        end else if (addr_i == rtc_ctl_pkg::OFS_HOUR_ALARM) begin
            read_value = cur.alarm_hour;
        end else if (addr_i == rtc_ctl_pkg::OFS_RATE_CTRL) begin
            // Pending update reads low while frozen.
            read_value = {update_pending_i && !cur.ctrl[rtc_ctl_pkg::CC_FREEZE],
                          cur.rate_ctrl};
        end else if (addr_i == rtc_ctl_pkg::OFS_CLOCK_CONTROL) begin
            read_value = cur.ctrl;
        end else if (addr_i == rtc_ctl_pkg::OFS_INTERRUPT_FLAGS) begin
            read_value = {any_irq(cur), cur.periodic_flag, cur.alarm_flag,
                          cur.update_done_flag, 4'h0};
        end else if (addr_i == rtc_ctl_pkg::OFS_BACKUP_STATUS) begin
            read_value = {|cur.supply_s2, 7'h00};
        end else if (in_ext && (addr_i == rtc_ctl_pkg::OFS_EXT_FLAGS)) begin
            read_value = {5'h00, cur.ext_flags};
        end else if (in_ext && (addr_i == rtc_ctl_pkg::OFS_EXT_ENABLES)) begin
            read_value = {2'h0, cur.force_32khz_out, 2'h0, cur.ext_en};
        end else if (in_ram) begin
            read_value = user_ram[ram_index];
        end

        // Outside a read the data lines rest at zero.
        next_state.rd_data = rd_en_i ? read_value : 8'h00;
    end

    // ============================================================
    // State register; power-up forces square-wave enable on.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            cur                 <= '0;
            cur.ctrl            <= rtc_ctl_pkg::RST_CLOCK_CONTROL;
            cur.rate_ctrl       <= rtc_ctl_pkg::RST_RATE_CTRL;
            cur.irq_n           <= 1'b1;
        end else begin
            cur <= next_state;
        end
    end

    // User RAM stays open to the host during update cycles.
    // RAM writes always allowed
    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i && in_ram) begin
            user_ram[ram_index] <= wr_data_i;
        end
    end

    // ============================================================
    // Outputs, all straight from the state register.
    // No logic sits here, so outputs move only on a clock edge.
    assign rd_data_o            = cur.rd_data;
    assign irq_n_o              = cur.irq_n;
    assign square_wave_out_o    = cur.square_wave_out;
    assign freeze_o             = cur.ctrl[rtc_ctl_pkg::CC_FREEZE];
    assign data_format_select_o = cur.ctrl[rtc_ctl_pkg::CC_DATA_FMT];
    assign hour_24_o            = cur.ctrl[rtc_ctl_pkg::CC_HOUR24];
    assign divider_ctrl_o       = cur.rate_ctrl[6:4];
    assign dst_skip_hour_o      = cur.dst_skip;
    assign dst_fall_back_o      = cur.dst_back;

endmodule

`default_nettype wire

// *** rtc_ctl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port-level checks of the clock control block.
module rtc_ctl_checker (
    // Clock, reset and host port.
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    input  wire logic [6:0] addr_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    input  wire logic [7:0] rd_data_o,
    // Timekeeping side and pins.
    input  wire logic       update_done_i,
    input  wire logic [7:0] count_hour_i,
    input  wire logic       vbat_ok_i,
    input  wire logic       vbaux_ok_i,
    input  wire logic       freeze_o,
    input  wire logic       data_format_select_o,
    input  wire logic       hour_24_o,
    input  wire logic       dst_skip_hour_o,
    input  wire logic       dst_fall_back_o,
    input  wire logic       irq_n_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    logic ctl_wr;
    logic flag_rd;
    logic stat_rd;

    // Decoded accesses that the checks key on.
    assign ctl_wr  = wr_en_i && addr_i == rtc_ctl_pkg::OFS_CLOCK_CONTROL;
    assign flag_rd = rd_en_i && addr_i == rtc_ctl_pkg::OFS_INTERRUPT_FLAGS;
    assign stat_rd = rd_en_i && addr_i == rtc_ctl_pkg::OFS_BACKUP_STATUS;

    // Read data, control bits and daylight-saving pulses.
    a_rd_data_idle: assert property (!$past(rd_en_i) |-> rd_data_o == 8'h00)
        else $error("Read data not zero outside a read.");
    a_flag_nibble_zero: assert property ($past(flag_rd) |-> rd_data_o[3:0] == 4'h0)
        else $error("Flag register low bits not zero.");
    a_summary_matches_irq: assert property ($past(flag_rd) |-> rd_data_o[7] == !$past(irq_n_o))
        else $error("Summary flag disagrees with interrupt pin.");
    a_status_low_zero: assert property ($past(stat_rd) |-> rd_data_o[6:0] == 7'h00)
        else $error("Status register low bits not zero.");
    a_status_valid_bit: assert property ($past(stat_rd) && $past(vbat_ok_i, 3) == vbat_ok_i
        && $past(vbaux_ok_i, 3) == vbaux_ok_i |-> rd_data_o[7] == (vbat_ok_i | vbaux_ok_i))
        else $error("Valid bit does not follow supplies.");
    a_freeze_follows: assert property ($past(ctl_wr) |-> freeze_o == $past(wr_data_i[7]))
        else $error("Freeze output does not follow write.");
    a_format_follows: assert property ($past(ctl_wr) |-> data_format_select_o == $past(wr_data_i[2]))
        else $error("Data format output does not follow write.");
    a_hour_follows: assert property ($past(ctl_wr) |-> hour_24_o == $past(wr_data_i[1]))
        else $error("Hour format output does not follow write.");
    a_skip_cause: assert property (dst_skip_hour_o |-> $past(update_done_i)
        && $past(count_hour_i) == rtc_ctl_pkg::HOUR_ONE ##1 !dst_skip_hour_o)
        else $error("Spring step without its cause.");
    a_fall_cause: assert property (dst_fall_back_o |-> $past(update_done_i)
        && $past(count_hour_i) == rtc_ctl_pkg::HOUR_ONE ##1 !dst_fall_back_o)
        else $error("Fall back without its cause.");
endmodule

bind rtc_ctl rtc_ctl_checker chk (.ref_clk_i, .reset_i, .addr_i, .wr_data_i, .wr_en_i,
    .rd_en_i, .rd_data_o, .update_done_i, .count_hour_i, .vbat_ok_i, .vbaux_ok_i, .freeze_o,
    .data_format_select_o, .hour_24_o, .dst_skip_hour_o, .dst_fall_back_o, .irq_n_o);
`default_nettype wire

// *** rtc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host processor: one-cycle register strobes, never both at once.
module rtc_host_model (
    // Clock and register port.
    input  wire logic       ref_clk_i,
    output logic      [6:0] addr_o,
    output logic      [7:0] wr_data_o,
    output logic            wr_en_o,
    output logic            rd_en_o,
    input  wire logic [7:0] rd_data_i
);
    // Idle bus at time zero.
    initial begin
        addr_o = 7'h00;
        wr_data_o = 8'h00;
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
    end
    // Write cycle; released lines show the inverse so stale values are not trusted.
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        addr_o <= a;
        wr_data_o <= v;
        wr_en_o <= 1'b1;
        @(posedge ref_clk_i);
        wr_en_o <= 1'b0;
        addr_o <= ~a;
        wr_data_o <= ~v;
        #1;
    endtask
    // Read cycle; data are taken in the cycle after the strobe.
    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        @(posedge ref_clk_i);
        addr_o <= a;
        rd_en_o <= 1'b1;
        @(posedge ref_clk_i);
        rd_en_o <= 1'b0;
        addr_o <= ~a;
        #1;
        v = rd_data_i;
    endtask
endmodule
`default_nettype wire

// *** rtc_ctl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bench: host model drives registers, the rest comes from here.
module rtc_ctl_test;
    localparam logic [6:0] cc = rtc_ctl_pkg::OFS_CLOCK_CONTROL;
    localparam logic [6:0] fl = rtc_ctl_pkg::OFS_INTERRUPT_FLAGS;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic [6:0]  addr;
    logic [7:0]  wr_data, rd_data, d;
    logic [7:0]  cs = 8'h00, cm = 8'h00, ch = 8'h00;
    logic        wr_en, rd_en, freeze, fmt, h24, skip, fall, square_wave_out, irq_n;
    logic [15:1] tap = '0;
    logic [5:0]  pl = '0;
    logic        fsa = 1'b0, lso = 1'b0, vbat = 1'b1, vbaux = 1'b0;
    int          errors = 0;
    int          comparisons = 0;
    int          seed = 67;
    int          k;
    int          af;

    // Clock at 125 MHz.
    always #4 ref_clk = ~ref_clk;

    rtc_host_model host (.ref_clk_i(ref_clk), .addr_o(addr), .wr_data_o(wr_data),
        .wr_en_o(wr_en), .rd_en_o(rd_en), .rd_data_i(rd_data));
    rtc_ctl dut (.ref_clk_i(ref_clk), .reset_i(reset), .addr_i(addr), .wr_data_i(wr_data),
        .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data), .rate_tap_i(tap),
        .tap_32khz_i(pl[5]), .update_pending_i(1'b0), .update_done_i(pl[3]),
        .count_sec_i(cs), .count_min_i(cm), .count_hour_i(ch), .midnight_i(pl[4]),
        .first_sunday_april_i(fsa), .last_sunday_october_i(lso), .wakeup_event_i(pl[0]),
        .kickstart_event_i(pl[1]), .ram_clear_event_i(pl[2]), .vbat_ok_i(vbat),
        .vbaux_ok_i(vbaux), .freeze_o(freeze), .data_format_select_o(fmt), .hour_24_o(h24),
        .divider_ctrl_o(), .dst_skip_hour_o(skip), .dst_fall_back_o(fall),
        .square_wave_out_o(square_wave_out), .irq_n_o(irq_n));

    // Compare helpers for bytes and single pins.
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    // One-cycle pulse on an event input; returns just after it is taken.
    task automatic pulse(input int b);
        @(posedge ref_clk);
        pl[b] <= 1'b1;
        @(posedge ref_clk);
        pl[b] <= 1'b0;
        #1;
    endtask
    task automatic final_report;
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hung sequence.
    initial begin
        #100000;
        errors++;
        final_report();
    end

    // Main sequence.
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        host.rd(cc, d);
        chk8(d, rtc_ctl_pkg::RST_CLOCK_CONTROL);
        host.wr(fl, 8'hff);
        host.wr(rtc_ctl_pkg::OFS_BACKUP_STATUS, 8'h7f);
        host.rd(fl, d);
        chk8(d, 8'h00);
        for (k = 0; k < 4; k++) begin
            vbat <= k[1];
            vbaux <= k[0];
            repeat (4) @(posedge ref_clk);
            host.rd(rtc_ctl_pkg::OFS_BACKUP_STATUS, d);
            chk8(d, {k != 0, 7'h00});
        end
        // Freeze, update-ended enable and format bits.
        host.wr(cc, 8'h1e);
        host.wr(cc, 8'h9e);
        host.rd(cc, d);
        chk8(d, 8'h8e);
        chk1(freeze, 1'b1);
        chk1(fmt, 1'b1);
        chk1(h24, 1'b1);
        cs <= 8'h01 | (8'h3e & 8'($random(seed)));
        pulse(3);
        host.rd(rtc_ctl_pkg::OFS_SEC, d);
        chk8(d, 8'h00);
        host.wr(cc, 8'h0e);
        pulse(3);
        host.rd(rtc_ctl_pkg::OFS_SEC, d);
        chk8(d, cs);
        host.rd(fl, d);
        chk8(d, 8'h10);
        // Periodic flag, square wave, late enable, clear on read.
        host.wr(rtc_ctl_pkg::OFS_RATE_CTRL, 8'h23);
        tap[3] <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        chk1(irq_n, 1'b1);
        chk1(square_wave_out, 1'b1);
        host.wr(cc, 8'h46);
        chk1(irq_n, 1'b0);
        host.rd(fl, d);
        chk8(d, 8'hc0);
        chk1(irq_n, 1'b1);
        chk1(square_wave_out, 1'b0);
        tap[3] <= 1'b0;
        fork
            host.rd(fl, d);
            begin
                @(posedge ref_clk);
                tap[3] <= 1'b1;
            end
        join
        chk8(d, 8'h00);
        host.rd(fl, d);
        chk8(d, 8'hc0);
        // Alarm match, mismatch and wildcard bytes.
        host.wr(cc, 8'h26);
        for (k = 0; k < 4; k++) begin
            cs <= 8'h3f & 8'($random(seed));
            cm <= 8'h3f & 8'($random(seed));
            ch <= 8'h3f & 8'($random(seed));
            @(posedge ref_clk);
            host.wr(rtc_ctl_pkg::OFS_SEC_ALARM, k == 3 ? 8'hff : cs);
            host.wr(rtc_ctl_pkg::OFS_MIN_ALARM, k == 3 ? 8'hff : cm);
            host.wr(rtc_ctl_pkg::OFS_HOUR_ALARM, k == 1 ? ch ^ 8'h01 : k == 0 ? ch : 8'hc0 | ch);
            pulse(3);
            af = (k != 1);
            chk1(irq_n, af == 0);
            host.rd(fl, d);
            chk8(d, af != 0 ? 8'hb0 : 8'h10);
        end
        // Daylight saving: spring once, fall once, nothing if armed while off.
        {cs, cm, ch} <= {8'h59, 8'h59, 8'h01};
        host.wr(cc, 8'h01);
        fsa <= 1'b1;
        pulse(4);
        fsa <= 1'b0;
        for (k = 0; k < 2; k++) begin
            pulse(3);
            chk1(skip, k == 0);
        end
        lso <= 1'b1;
        pulse(4);
        for (k = 0; k < 2; k++) begin
            pulse(3);
            chk1(fall, k == 0);
        end
        host.wr(cc, 8'h00);
        pulse(4);
        host.wr(cc, 8'h01);
        pulse(3);
        chk1(fall, 1'b0);
        // Extended sources in bank 1; stale flags cleared first.
        host.wr(rtc_ctl_pkg::OFS_RATE_CTRL, 8'h30);
        host.wr(cc, 8'h00);
        host.rd(fl, d);
        for (k = 0; k < 3; k++) begin
            pulse(k);
            chk1(irq_n, 1'b1);
            host.wr(rtc_ctl_pkg::OFS_EXT_ENABLES, 8'h07);
            chk1(irq_n, 1'b0);
            host.rd(fl, d);
            chk8(d, 8'h80);
            host.rd(rtc_ctl_pkg::OFS_EXT_FLAGS, d);
            chk8(d, 8'h01 << k);
            host.wr(rtc_ctl_pkg::OFS_EXT_FLAGS, 8'h00);
            chk1(irq_n, 1'b1);
            host.wr(rtc_ctl_pkg::OFS_EXT_ENABLES, 8'h00);
        end
        host.wr(rtc_ctl_pkg::OFS_EXT_ENABLES, 8'h20);
        pl[5] <= 1'b1;
        host.rd(rtc_ctl_pkg::OFS_EXT_ENABLES, d);
        chk8(d, 8'h20);
        chk1(square_wave_out, 1'b1);
        // User RAM in both banks and an unmapped extended place.
        cs <= 8'($random(seed));
        cm <= 8'($random(seed));
        @(posedge ref_clk);
        host.wr(7'h0e, cs);
        host.rd(7'h7f, d);
        chk8(d, 8'h00);
        host.wr(rtc_ctl_pkg::OFS_RATE_CTRL, 8'h20);
        host.wr(7'h7f, cm);
        host.rd(7'h7f, d);
        chk8(d, cm);
        host.rd(7'h0e, d);
        chk8(d, cs);
        final_report();
    end
endmodule
`default_nettype wire
